//--- src/srs_pkg.sv
package srs_pkg;

    // ----------------------------------------------------------------
    // delay sequence
    // ----------------------------------------------------------------
    localparam int OSC_CNT_W = 7;
    localparam int CLK_CNT_W = 5;
    localparam logic [OSC_CNT_W-1:0] POR_OSC_CYCLES = 7'h42;
    localparam logic [CLK_CNT_W-1:0] SETTLE_CLK_CYCLES = 5'h10;
    localparam logic [OSC_CNT_W-1:0] OSC_CNT_LAST = POR_OSC_CYCLES - 7'h01;
    localparam logic [CLK_CNT_W-1:0] CLK_CNT_LAST = SETTLE_CLK_CYCLES - 5'h01;
    localparam logic [OSC_CNT_W-1:0] OSC_CNT_ZERO = 7'h00;
    localparam logic [CLK_CNT_W-1:0] CLK_CNT_ZERO = 5'h00;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    localparam int SYNC_N = 4;
    localparam int SYNC_SUPPLY = 0;
    localparam int SYNC_RSTPIN = 1;
    localparam int SYNC_DBGPIN = 2;
    localparam int SYNC_WDTOSC = 3;
    // supply assumed low, active-low pins idle high, oscillator low
    localparam logic [SYNC_N-1:0] SYNC_RESET_VAL = 4'h7;

    // ----------------------------------------------------------------
    // sequencer states
    // ----------------------------------------------------------------
    typedef enum logic [4:0] {
        SRS_POR_WAIT = 5'h01,
        SRS_OSC_COUNT = 5'h02,
        SRS_CLK_COUNT = 5'h04,
        SRS_HOLD = 5'h08,
        SRS_RUN = 5'h10
    } srs_state_type;

    // ----------------------------------------------------------------
    // reset requests
    // ----------------------------------------------------------------
    typedef struct packed {
        logic por;
        logic wdt;
        logic pin;
        logic ocd;
        logic dbg;
    } srs_src_type;

endpackage : srs_pkg

//--- src/srs_sync3.sv
`timescale 1ns/10ps
module srs_sync3 #(
    parameter logic RESET_VAL = 1'h0
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic async_in,
    output logic sync_out
);
    logic meta_q;
    logic s2_q;
    logic s3_q;
    logic out_q;

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
        begin
            meta_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
        end
        else
        begin
            meta_q <= async_in;
            s2_q <= meta_q;
            s3_q <= s2_q;
        end
    end

    // a change counts only once the last two stages agree
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            out_q <= RESET_VAL;
        else if (s2_q == s3_q)
            out_q <= s3_q;
    end

    assign sync_out = out_q;

endmodule : srs_sync3

//--- src/srs_sequencer.sv
// Function
// - in normal or halt, low supply detection causes full system reset
// - watchdog time-out resets the system only when configured for reset
// - in normal or halt, external reset pin causes system reset
// - debugger control bit 0 resets system but leaves debugger logic running
// - in stop mode, low supply detection still causes system reset
// - in stop mode, reset pin or debug pin low causes system reset
// - after supply is good, count 66 watchdog oscillator cycles
// - then count 16 system clock pulses
// - reset stays asserted until both counters have expired
// - leaving reset lets the core fetch its reset vector
// - after power-on reset completes, set the power-on status flag
`timescale 1ns/10ps
module srs_sequencer
    import srs_pkg::*;
(
    input wire logic clock,
    input wire logic rstn,
    input wire logic supply_low,
    input wire logic reset_pin_n,
    input wire logic debug_pin_n,
    input wire logic wdt_osc,
    input wire logic stop_mode,
    input wire logic wdt_timeout,
    input wire logic wdt_reset_mode,
    input wire logic debugger_reset_bit,
    input wire logic por_status_clear,
    output logic sys_reset_n,
    output logic debugger_reset_n,
    output logic fetch_vector,
    output logic por_status,
    output srs_src_type reset_cause
);

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [SYNC_N-1:0] async_in;
    logic [SYNC_N-1:0] sync_in;

    assign async_in[SYNC_SUPPLY] = supply_low;
    assign async_in[SYNC_RSTPIN] = reset_pin_n;
    assign async_in[SYNC_DBGPIN] = debug_pin_n;
    assign async_in[SYNC_WDTOSC] = wdt_osc;

    genvar gi;
    generate
        for (gi = 0; gi < SYNC_N; gi++)
        begin : g_sync
            srs_sync3 #(
                .RESET_VAL(SYNC_RESET_VAL[gi])
            ) u_sync (
                .clock(clock),
                .rstn(rstn),
                .async_in(async_in[gi]),
                .sync_out(sync_in[gi])
            );
        end
    endgenerate

    logic supply_low_s;
    logic reset_pin_n_s;
    logic debug_pin_n_s;
    logic osc_s;
    logic osc_prev_q;
    logic osc_edge;

    assign supply_low_s = sync_in[SYNC_SUPPLY];
    assign reset_pin_n_s = sync_in[SYNC_RSTPIN];
    assign debug_pin_n_s = sync_in[SYNC_DBGPIN];
    assign osc_s = sync_in[SYNC_WDTOSC];

    // slow oscillator is sampled, so its rising edges are detected here
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            osc_prev_q <= 1'h0;
        else
            osc_prev_q <= osc_s;
    end

    assign osc_edge = osc_s & ~osc_prev_q;

    // ----------------------------------------------------------------
    // reset sources
    // ----------------------------------------------------------------
    srs_src_type src;
    logic other_src;

    always_comb
    begin
        src.por = supply_low_s;
        src.wdt = ~stop_mode & wdt_timeout & wdt_reset_mode;
        src.pin = ~reset_pin_n_s;
        src.ocd = ~stop_mode & debugger_reset_bit;
        src.dbg = stop_mode & ~debug_pin_n_s;
    end

    assign other_src = src.wdt | src.pin | src.ocd | src.dbg;

    // ----------------------------------------------------------------
    // sequencer
    // ----------------------------------------------------------------
    srs_state_type state_q;
    srs_state_type state_d;
    logic [OSC_CNT_W-1:0] osc_cnt_q;
    logic [CLK_CNT_W-1:0] clk_cnt_q;
    logic por_seq_q;

    always_comb
    begin
        state_d = state_q;
        unique case (state_q)
            SRS_POR_WAIT:
                if (!src.por)
                    state_d = SRS_OSC_COUNT;
            SRS_OSC_COUNT:
                if (osc_edge && osc_cnt_q == OSC_CNT_LAST)
                    state_d = SRS_CLK_COUNT;
            SRS_CLK_COUNT:
                if (other_src)
                    state_d = SRS_HOLD;
                else if (clk_cnt_q == CLK_CNT_LAST)
                    state_d = SRS_RUN;
            SRS_HOLD:
                if (!other_src)
                    state_d = SRS_CLK_COUNT;
            SRS_RUN:
                if (other_src)
                    state_d = SRS_HOLD;
            default:
                state_d = SRS_POR_WAIT;
        endcase
        // low supply overrides every state and restarts the delay
        if (src.por)
            state_d = SRS_POR_WAIT;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            state_q <= SRS_POR_WAIT;
        else
            state_q <= state_d;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            osc_cnt_q <= OSC_CNT_ZERO;
        else if (state_q != SRS_OSC_COUNT || state_d != SRS_OSC_COUNT)
            osc_cnt_q <= OSC_CNT_ZERO;
        else if (osc_edge)
            osc_cnt_q <= osc_cnt_q + 7'h01;
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            clk_cnt_q <= CLK_CNT_ZERO;
        else if (state_q != SRS_CLK_COUNT || state_d != SRS_CLK_COUNT)
            clk_cnt_q <= CLK_CNT_ZERO;
        else
            clk_cnt_q <= clk_cnt_q + 5'h01;
    end

    // marks a sequence that began with a power-on event
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            por_seq_q <= 1'h1;
        else if (state_d == SRS_POR_WAIT)
            por_seq_q <= 1'h1;
        else if (state_d == SRS_RUN)
            por_seq_q <= 1'h0;
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    logic sys_reset_n_q;
    logic debugger_reset_n_q;
    logic fetch_vector_q;
    logic por_status_q;
    srs_src_type reset_cause_q;
    logic leaving;

    assign leaving = (state_q != SRS_RUN) && (state_d == SRS_RUN);

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            sys_reset_n_q <= 1'h0;
        else
            sys_reset_n_q <= (state_d == SRS_RUN);
    end

    // debugger only sees the power-on part of the sequence
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            debugger_reset_n_q <= 1'h0;
        else
            debugger_reset_n_q <= (state_d != SRS_POR_WAIT)
                && (state_d != SRS_OSC_COUNT);
    end

    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            fetch_vector_q <= 1'h0;
        else
            fetch_vector_q <= leaving;
    end

    // set wins over a clear in the same cycle
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            por_status_q <= 1'h0;
        else if (leaving && por_seq_q)
            por_status_q <= 1'h1;
        else if (por_status_clear)
            por_status_q <= 1'h0;
    end

    // latest cause, kept until the next reset event
    always_ff @(posedge clock or negedge rstn)
    begin
        if (!rstn)
            reset_cause_q <= '0;
        else if (src.por || (other_src && state_q != SRS_POR_WAIT
                 && state_q != SRS_OSC_COUNT))
            reset_cause_q <= src;
    end

    assign sys_reset_n = sys_reset_n_q;
    assign debugger_reset_n = debugger_reset_n_q;
    assign fetch_vector = fetch_vector_q;
    assign por_status = por_status_q;
    assign reset_cause = reset_cause_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence s_osc_done;
        state_q == SRS_OSC_COUNT && osc_edge && osc_cnt_q == OSC_CNT_LAST && !src.por;
    endsequence
    sequence s_clk_done;
        state_q == SRS_CLK_COUNT && clk_cnt_q == CLK_CNT_LAST && !src.por && !other_src;
    endsequence
    // supply may recover one cycle later, so only the reset output is held two cycles
    a_supply_low_resets: assert property (@(posedge clock) disable iff (!rstn)
        src.por |=> state_q == SRS_POR_WAIT && !sys_reset_n_q ##1 !sys_reset_n_q)
        else $error("low supply did not hold reset");
    a_stop_supply_low: assert property (@(posedge clock) disable iff (!rstn)
        stop_mode && supply_low_s && state_q == SRS_RUN |=> !sys_reset_n_q && !debugger_reset_n_q)
        else $error("low supply in stop mode ignored");
    a_wdt_mode_gate: assert property (@(posedge clock) disable iff (!rstn)
        state_q == SRS_RUN && wdt_timeout && !wdt_reset_mode && !src.por && !src.pin
        && !src.ocd && !src.dbg |=> sys_reset_n_q)
        else $error("watchdog reset while in interrupt mode");
    a_pin_reset: assert property (@(posedge clock) disable iff (!rstn)
        state_q == SRS_RUN && !reset_pin_n_s |=> !sys_reset_n_q ##1 !sys_reset_n_q)
        else $error("reset pin not honoured");
    a_ocd_keeps_dbg: assert property (@(posedge clock) disable iff (!rstn)
        state_q == SRS_RUN && debugger_reset_bit && !stop_mode && !src.por
        |=> !sys_reset_n_q && debugger_reset_n_q)
        else $error("debugger reset wrong");
    a_dbg_pin_stop: assert property (@(posedge clock) disable iff (!rstn)
        state_q == SRS_RUN && !debug_pin_n_s && stop_mode |=> !sys_reset_n_q)
        else $error("debug pin low in stop mode ignored");
    a_osc_to_clk: assert property (@(posedge clock) disable iff (!rstn)
        s_osc_done |=> state_q == SRS_CLK_COUNT && clk_cnt_q == CLK_CNT_ZERO)
        else $error("oscillator count did not hand over");
    a_clk_count_len: assert property (@(posedge clock) disable iff (!rstn)
        $rose(state_q == SRS_CLK_COUNT) && !src.por && !other_src ##1
        (!src.por && !other_src) [*8] |-> !sys_reset_n_q)
        else $error("clock count ended early");
    a_release_cause: assert property (@(posedge clock) disable iff (!rstn)
        $rose(sys_reset_n_q) |-> $past(state_q) == SRS_CLK_COUNT
        && $past(clk_cnt_q) == CLK_CNT_LAST)
        else $error("reset released before counters expired");
    a_fetch_pulse: assert property (@(posedge clock) disable iff (!rstn)
        s_clk_done |=> fetch_vector_q && sys_reset_n_q ##1 !fetch_vector_q)
        else $error("fetch pulse missing or long");
    a_por_flag: assert property (@(posedge clock) disable iff (!rstn)
        s_clk_done ##0 por_seq_q |=> por_status_q)
        else $error("power-on status not set");
    a_por_restart: assert property (@(posedge clock) disable iff (!rstn)
        (state_q == SRS_OSC_COUNT || state_q == SRS_CLK_COUNT) && src.por
        |=> osc_cnt_q == OSC_CNT_ZERO && clk_cnt_q == CLK_CNT_ZERO && !sys_reset_n_q)
        else $error("delay not restarted");

endmodule : srs_sequencer

//--- tb/srs_partner.sv
`timescale 1ns/10ps
// ------------------------------------------------
// watchdog oscillator and supply monitor
// ------------------------------------------------
module srs_partner
    import srs_pkg::*;
(
    input wire logic brownout,
    output logic wdt_osc,
    output logic supply_low
);
    // free running; every toggle lands on a falling clock edge, clear of sampling
    initial
    begin
        wdt_osc = 1'b0;
        forever #260 wdt_osc = ~wdt_osc;
    end

    assign supply_low = brownout;
endmodule : srs_partner

//--- tb/srs_sequencer_bench.sv
`timescale 1ns/10ps
module srs_sequencer_bench
    import srs_pkg::*;
();
    // ------------------------------------------------
    // signals
    // ------------------------------------------------
    logic clock, rstn, brownout, supply_low, wdt_osc, reset_pin_n, debug_pin_n;
    logic stop_mode, wdt_timeout, wdt_reset_mode, debugger_reset_bit, por_status_clear;
    logic sys_reset_n, debugger_reset_n, fetch_vector, por_status;
    srs_src_type reset_cause;
    int error_cnt = 0;
    int total_checks = 0;
    int osc_edges = 0;
    time last_edge_t = 0;

    srs_partner u_partner (
        .brownout(brownout),
        .wdt_osc(wdt_osc),
        .supply_low(supply_low)
    );

    srs_sequencer u_dut (
        .clock(clock),
        .rstn(rstn),
        .supply_low(supply_low),
        .reset_pin_n(reset_pin_n),
        .debug_pin_n(debug_pin_n),
        .wdt_osc(wdt_osc),
        .stop_mode(stop_mode),
        .wdt_timeout(wdt_timeout),
        .wdt_reset_mode(wdt_reset_mode),
        .debugger_reset_bit(debugger_reset_bit),
        .por_status_clear(por_status_clear),
        .sys_reset_n(sys_reset_n),
        .debugger_reset_n(debugger_reset_n),
        .fetch_vector(fetch_vector),
        .por_status(por_status),
        .reset_cause(reset_cause)
    );

    initial clock = 1'b0;
    always #10 clock = ~clock;

    always @(posedge wdt_osc)
    begin
        osc_edges++;
        last_edge_t = $time;
    end

    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic check(input logic got, input logic exp, input string what);
        total_checks++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("[ERR] %0t %s", $time, what);
        end
    endtask : check

    // packed {por, wdt, pin, ocd, dbg}, one bit per source index
    function automatic logic [4:0] cause_of(input int idx);
        case (idx)
            0: cause_of = 5'h10;
            1: cause_of = 5'h04;
            2: cause_of = 5'h01;
            3: cause_of = 5'h08;
            default: cause_of = 5'h02;
        endcase
    endfunction : cause_of

    task automatic end_of_test;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask : end_of_test

    // bounded wait, sampled at the falling edge
    task automatic wait_rst(input logic lvl, input int max, output int n);
        n = 0;
        while (sys_reset_n !== lvl && n < max)
        begin
            @(negedge clock);
            n++;
        end
    endtask : wait_rst

    task automatic set_src(input int idx, input logic on);
        case (idx)
            0: brownout = on;
            1: reset_pin_n = ~on;
            2: debug_pin_n = ~on;
            3: wdt_timeout = on;
            default: debugger_reset_bit = on;
        endcase
    endtask : set_src

    task automatic por_seq(input logic restart);
        int n;
        int base;
        @(negedge clock);
        brownout = 1'b1;
        por_status_clear = 1'b1;
        @(negedge clock);
        por_status_clear = 1'b0;
        check(por_status, 1'b0, "flag not cleared");
        repeat (7) @(negedge clock);
        brownout = 1'b0;
        base = osc_edges;
        if (restart)
        begin
            wait (osc_edges == base + 30);
            @(negedge clock);
            check(sys_reset_n, 1'b0, "released mid delay");
            brownout = 1'b1;
            repeat (8) @(negedge clock);
            brownout = 1'b0;
            base = osc_edges;
        end
        wait_rst(1'b1, 2500, n);
        check(sys_reset_n, 1'b1, "no release");
        check(logic'(osc_edges - base inside {[66:68]}), 1'b1, "osc count");
        check(logic'($time - last_edge_t inside {[320:490]}), 1'b1, "clock count");
        check(fetch_vector, 1'b1, "no vector fetch");
        check(por_status, 1'b1, "flag not set");
        check(debugger_reset_n, 1'b1, "debugger held");
        check(logic'(reset_cause === cause_of(0)), 1'b1, "reset cause");
        $display("power-on test %0d done", restart);
    endtask : por_seq

    task automatic src_test(input int idx, input logic stop, input logic mode, input logic hit);
        int n;
        @(negedge clock);
        por_status_clear = 1'b1;
        stop_mode = stop;
        wdt_reset_mode = mode;
        @(negedge clock);
        por_status_clear = 1'b0;
        set_src(idx, 1'b1);
        wait_rst(1'b0, 12, n);
        check(sys_reset_n, ~hit, "reset response");
        if (hit)
        begin
            repeat (2) @(negedge clock);
            check(debugger_reset_n, logic'(idx != 0), "debugger reset");
        end
        set_src(idx, 1'b0);
        stop_mode = 1'b0;
        if (hit)
        begin
            wait_rst(1'b1, 2500, n);
            check(sys_reset_n, 1'b1, "no release");
            check(fetch_vector, 1'b1, "no vector fetch");
            check(por_status, logic'(idx == 0), "flag wrong");
            check(logic'(reset_cause === cause_of(idx)), 1'b1, "reset cause");
            if (idx != 0)
                check(logic'(n inside {[17:24]}), 1'b1, "settle count");
            @(negedge clock);
            check(fetch_vector, 1'b0, "fetch not a pulse");
        end
        // synced pins lag the bench by four clocks; a stale level would leak into the next test
        repeat (6) @(negedge clock);
        $display("source test %0d done", idx);
    endtask : src_test

    // ------------------------------------------------
    // sequence
    // ------------------------------------------------
    initial
    begin
        rstn = 1'b0;
        brownout = 1'b0;
        reset_pin_n = 1'b1;
        debug_pin_n = 1'b1;
        stop_mode = 1'b0;
        wdt_timeout = 1'b0;
        wdt_reset_mode = 1'b0;
        debugger_reset_bit = 1'b0;
        por_status_clear = 1'b0;
        repeat (12) @(negedge clock);
        check(sys_reset_n, 1'b0, "reset output");
        check(por_status, 1'b0, "reset flag");
        check(debugger_reset_n, 1'b0, "debugger reset output");
        check(fetch_vector, 1'b0, "fetch in reset");
        rstn = 1'b1;
        por_seq(1'b0);
        por_seq(1'b1);
        src_test(1, 1'b0, 1'b0, 1'b1);
        src_test(3, 1'b0, 1'b0, 1'b0);
        src_test(3, 1'b0, 1'b1, 1'b1);
        src_test(4, 1'b0, 1'b0, 1'b1);
        src_test(2, 1'b0, 1'b0, 1'b0);
        src_test(2, 1'b1, 1'b0, 1'b1);
        src_test(1, 1'b1, 1'b0, 1'b1);
        src_test(3, 1'b1, 1'b1, 1'b0);
        src_test(0, 1'b0, 1'b0, 1'b1);
        src_test(0, 1'b1, 1'b0, 1'b1);
        end_of_test();
    end

    // about 8k cycles expected (four oscillator delays); limit well past that
    initial
    begin
        #600_000;
        error_cnt++;
        $display("[ERR] %0t watchdog expired", $time);
        end_of_test();
    end
endmodule : srs_sequencer_bench
